//--- rtl/cfe_flags_cond.v
// cpu control state: mask, flags, register pointer, stack pointer,
// plus the jump condition evaluator.
// assumes a single clock; the core supplies register-file accesses
// and per-instruction flag effects on the same edge.
`timescale 1ns/10ps
`include "cfe_regs.vh"

module cfe_flags_cond #(
   parameter RAM_PROTECT_OPTION = 1'b1
) (
   input wire clk,
   input wire rst_n,
   input wire [7:0] regAddr,
   input wire regWrEn,
   input wire [7:0] regWrData,
   input wire regRdEn,
   output reg [7:0] regRdData,
   output reg regRdHit,
   input wire eiStrobe,
   input wire diStrobe,
   input wire flagUpdEn,
   input wire [17:0] flagEffect,
   input wire [5:0] flagResult,
   input wire spLoadEn,
   input wire [15:0] spLoadValue,
   input wire [3:0] condCode,
   output wire condTrue,
   output wire [5:0] irqEnable,
   output wire irqGlobalEnable,
   output wire ramProtectActive,
   output wire [3:0] workGroup,
   output wire [3:0] extBank,
   output wire [15:0] stackTopPointer,
   output wire [7:0] flagsValue
);

   reg [7:0] irqMaskCtrl_r;
   reg [7:0] aluStatusFlags_r;
   reg [7:0] workingRegBase_r;
   reg [7:0] stackPtrUpper_r;
   reg [7:0] stackPtrLower_r;
   reg [7:0] flagsAfterOp_nxt;
   wire [5:0] statusNext;
   reg [7:0] regRdData_nxt;
   reg regRdHit_nxt;
   reg condTrue_nxt;

   wire wrMask = regWrEn && (regAddr == `CFE_ADDR_IRQ_MASK);
   wire wrFlags = regWrEn && (regAddr == `CFE_ADDR_FLAGS);
   wire wrBase = regWrEn && (regAddr == `CFE_ADDR_WRK_BASE);
   wire wrSpHi = regWrEn && (regAddr == `CFE_ADDR_SP_UPPER);
   wire wrSpLo = regWrEn && (regAddr == `CFE_ADDR_SP_LOWER);

   wire flgC = aluStatusFlags_r[`CFE_FLG_C];
   wire flgZ = aluStatusFlags_r[`CFE_FLG_Z];
   wire flgS = aluStatusFlags_r[`CFE_FLG_S];
   wire flgV = aluStatusFlags_r[`CFE_FLG_V];

   // ****************************************************
   // interrupt mask register
   // ****************************************************
   // a direct write takes priority over ei/di in the same cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         irqMaskCtrl_r <= `CFE_RST_IRQ_MASK;
      end else if (wrMask) begin
         irqMaskCtrl_r <= regWrData;
      end else if (eiStrobe) begin
         irqMaskCtrl_r[`CFE_IMR_GIE] <= 1'b1;
      end else if (diStrobe) begin
         irqMaskCtrl_r[`CFE_IMR_GIE] <= 1'b0;
      end
   end

   assign irqEnable = irqMaskCtrl_r[`CFE_IMR_SRC_HI:0];
   assign irqGlobalEnable = irqMaskCtrl_r[`CFE_IMR_GIE];
   // bit is stored either way but only protects on fitted parts
   assign ramProtectActive = RAM_PROTECT_OPTION &&
      irqMaskCtrl_r[`CFE_IMR_RAMP];

   // ****************************************************
   // flag register
   // ****************************************************
   // effect fields: 3 bits per status flag, flag c in the top field.
   // undefined is resolved as keep, a safe deterministic choice.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : gFlag
         wire [2:0] fx = flagEffect[3*gi+2:3*gi];
         reg bitNext;
         always @* begin
            case (fx)
               `CFE_FX_CLR: bitNext = 1'b0;
               `CFE_FX_SET: bitNext = 1'b1;
               `CFE_FX_RES: bitNext = flagResult[gi];
               default: bitNext = aluStatusFlags_r[gi+2];
            endcase
         end
         assign statusNext[gi] = bitNext;
      end
   endgenerate

   // user flags change only by software writes
   always @* begin
      flagsAfterOp_nxt = {statusNext, aluStatusFlags_r[1:0]};
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         aluStatusFlags_r <= `CFE_RST_FLAGS;
      end else if (wrFlags) begin
         aluStatusFlags_r <= regWrData;
      end else if (flagUpdEn) begin
         aluStatusFlags_r <= flagsAfterOp_nxt;
      end
   end

   assign flagsValue = aluStatusFlags_r;

   // ****************************************************
   // register pointer and stack pointer
   // ****************************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         workingRegBase_r <= `CFE_RST_WRK_BASE;
      end else if (wrBase) begin
         workingRegBase_r <= regWrData;
      end
   end

   assign workGroup = workingRegBase_r[7:4];
   assign extBank = workingRegBase_r[3:0];

   // software byte writes win over a core push/pop load
   always @(posedge clk) begin
      if (!rst_n) begin
         stackPtrUpper_r <= `CFE_RST_SP;
         stackPtrLower_r <= `CFE_RST_SP;
      end else begin
         if (wrSpHi) begin
            stackPtrUpper_r <= regWrData;
         end else if (spLoadEn) begin
            stackPtrUpper_r <= spLoadValue[15:8];
         end
         if (wrSpLo) begin
            stackPtrLower_r <= regWrData;
         end else if (spLoadEn) begin
            stackPtrLower_r <= spLoadValue[7:0];
         end
      end
   end

   assign stackTopPointer = {stackPtrUpper_r, stackPtrLower_r};

   // ****************************************************
   // read port
   // ****************************************************
   always @* begin
      regRdHit_nxt = 1'b1;
      case (regAddr)
         `CFE_ADDR_IRQ_MASK: regRdData_nxt = irqMaskCtrl_r;
         `CFE_ADDR_FLAGS: regRdData_nxt = aluStatusFlags_r;
         `CFE_ADDR_WRK_BASE: regRdData_nxt = workingRegBase_r;
         `CFE_ADDR_SP_UPPER: regRdData_nxt = stackPtrUpper_r;
         `CFE_ADDR_SP_LOWER: regRdData_nxt = stackPtrLower_r;
         default: begin
            regRdData_nxt = 8'h00;
            regRdHit_nxt = 1'b0;
         end
      endcase
   end

   // read data registered: valid the cycle after regRdEn
   always @(posedge clk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
         regRdHit <= 1'b0;
      end else if (regRdEn) begin
         regRdData <= regRdData_nxt;
         regRdHit <= regRdHit_nxt;
      end else begin
         regRdHit <= 1'b0;
      end
   end

   // ****************************************************
   // condition evaluator
   // ****************************************************
   // combinational so a jump can decide in the same cycle
   always @* begin
      case (condCode)
         `CFE_CC_NEVER: condTrue_nxt = 1'b0;
         `CFE_CC_ALWAYS: condTrue_nxt = 1'b1;
         `CFE_CC_GT: condTrue_nxt = ~(flgZ | (flgS ^ flgV));
         `CFE_CC_LE: condTrue_nxt = flgZ | (flgS ^ flgV);
         `CFE_CC_UGT: condTrue_nxt = ~flgC & ~flgZ;
         `CFE_CC_ULE: condTrue_nxt = flgC | flgZ;
         `CFE_CC_UGE: condTrue_nxt = ~flgC;
         `CFE_CC_LT: condTrue_nxt = flgS ^ flgV;
         `CFE_CC_GE: condTrue_nxt = ~(flgS ^ flgV);
         `CFE_CC_EQ: condTrue_nxt = flgZ;
         `CFE_CC_NE: condTrue_nxt = ~flgZ;
         `CFE_CC_ULT: condTrue_nxt = flgC;
         `CFE_CC_OV: condTrue_nxt = flgV;
         `CFE_CC_NOV: condTrue_nxt = ~flgV;
         `CFE_CC_MI: condTrue_nxt = flgS;
         `CFE_CC_PL: condTrue_nxt = ~flgS;
         default: condTrue_nxt = 1'b0;
      endcase
   end

   assign condTrue = condTrue_nxt;

endmodule // cfe_flags_cond

//--- rtl/cfe_regs.vh
// control register addresses, field positions and reset values
// for the cpu flag, mask, pointer and stack control block
`ifndef CFE_REGS_VH
`define CFE_REGS_VH

`define CFE_ADDR_IRQ_MASK 8'hfb
`define CFE_ADDR_FLAGS 8'hfc
`define CFE_ADDR_WRK_BASE 8'hfd
`define CFE_ADDR_SP_UPPER 8'hfe
`define CFE_ADDR_SP_LOWER 8'hff

`define CFE_IMR_GIE 7
`define CFE_IMR_RAMP 6
`define CFE_IMR_SRC_HI 5

`define CFE_FLG_C 7
`define CFE_FLG_Z 6
`define CFE_FLG_S 5
`define CFE_FLG_V 4
`define CFE_FLG_D 3
`define CFE_FLG_H 2
`define CFE_FLG_F2 1
`define CFE_FLG_F1 0

`define CFE_RST_IRQ_MASK 8'h00
`define CFE_RST_FLAGS 8'h00
`define CFE_RST_WRK_BASE 8'h00
`define CFE_RST_SP 8'h00

// per-flag effect codes
`define CFE_FX_KEEP 3'h0
`define CFE_FX_CLR 3'h1
`define CFE_FX_SET 3'h2
`define CFE_FX_RES 3'h3
`define CFE_FX_UNDEF 3'h4

// condition codes
`define CFE_CC_NEVER 4'h0
`define CFE_CC_LT 4'h1
`define CFE_CC_LE 4'h2
`define CFE_CC_ULE 4'h3
`define CFE_CC_OV 4'h4
`define CFE_CC_MI 4'h5
`define CFE_CC_EQ 4'h6
`define CFE_CC_ULT 4'h7
`define CFE_CC_ALWAYS 4'h8
`define CFE_CC_GE 4'h9
`define CFE_CC_GT 4'ha
`define CFE_CC_UGT 4'hb
`define CFE_CC_NOV 4'hc
`define CFE_CC_PL 4'hd
`define CFE_CC_NE 4'he
`define CFE_CC_UGE 4'hf

`endif

//--- sim/cfe_flags_cond_assertions.sv
// assertion checker for the flag, mask and condition block
// assumes binding to the block's top ports, one clock domain
`timescale 1ns/10ps
module cfe_flags_cond_assertions (
   input wire clk,
   input wire rst_n,
   input wire [7:0] regAddr,
   input wire regWrEn,
   input wire [7:0] regWrData,
   input wire regRdEn,
   input wire regRdHit,
   input wire eiStrobe,
   input wire [3:0] condCode,
   input wire condTrue,
   input wire irqGlobalEnable,
   input wire [3:0] workGroup,
   input wire [3:0] extBank,
   input wire [7:0] flagsValue
);
   wire c = flagsValue[7];
   wire z = flagsValue[6];
   wire sv = flagsValue[5] ^ flagsValue[4];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ******
   // condition and register checks
   // ******
   fixed_cc_a: assert property (condCode[2:0] == 3'h0 |-> condTrue == condCode[3])
      else $error("fixed code wrong");
   sgt_cc_a: assert property (condCode == 4'ha |-> condTrue == !(z | sv))
      else $error("signed above wrong");
   sle_cc_a: assert property (condCode == 4'h2 |-> condTrue == (z | sv))
      else $error("signed at most wrong");
   ugt_cc_a: assert property (condCode == 4'hb |-> condTrue == !(c | z))
      else $error("unsigned above wrong");
   ule_cc_a: assert property (condCode == 4'h3 |-> condTrue == (c | z))
      else $error("unsigned at most wrong");
   uge_cc_a: assert property (condCode == 4'hf |-> condTrue == !c)
      else $error("unsigned at least wrong");
   slt_cc_a: assert property (condCode == 4'h1 |-> condTrue == sv)
      else $error("signed below wrong");
   ei_set_a: assert property (eiStrobe && !(regWrEn && regAddr == 8'hfb)
      |=> irqGlobalEnable)
      else $error("global enable not set");
   base_write_a: assert property (regWrEn && regAddr == 8'hfd
      |=> {workGroup, extBank} == $past(regWrData))
      else $error("pointer write lost");
   read_hit_a: assert property (regRdEn
      |=> regRdHit == ($past(regAddr) >= 8'hfb))
      else $error("read hit wrong");
   cover property (regRdHit);
   cover property (eiStrobe);
   cover property (condCode == 4'ha && condTrue);
endmodule // cfe_flags_cond_assertions

//--- sim/tb_cfe_flags_cond.sv
// self-checking bench for the flag, mask and condition block
// assumes reads answer one cycle after the strobe edge
`timescale 1ns/10ps
module tb_cfe_flags_cond;
   logic clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, eiStrobe = 0;
   logic diStrobe = 0, flagUpdEn = 0, spLoadEn = 0;
   logic [7:0] regAddr = '0, regWrData = '0, f;
   logic [17:0] flagEffect = '0;
   logic [5:0] flagResult = '0;
   logic [15:0] spLoadValue = '0, sp;
   logic [3:0] condCode = '0;
   wire [7:0] regRdData, flagsValue;
   wire regRdHit, condTrue, irqGlobalEnable, ramProtectActive;
   wire [5:0] irqEnable;
   wire [3:0] workGroup, extBank;
   wire [15:0] stackTopPointer;
   logic [7:0] q[$];
   int err_total = 0, samples_checked = 0, cyc = 0;
   always #5 clk = ~clk;
   cfe_flags_cond cfe_flags_cond_i (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdEn(regRdEn), .regRdData(regRdData), .regRdHit(regRdHit),
      .eiStrobe(eiStrobe), .diStrobe(diStrobe), .flagUpdEn(flagUpdEn),
      .flagEffect(flagEffect), .flagResult(flagResult),
      .spLoadEn(spLoadEn), .spLoadValue(spLoadValue),
      .condCode(condCode), .condTrue(condTrue), .irqEnable(irqEnable),
      .irqGlobalEnable(irqGlobalEnable),
      .ramProtectActive(ramProtectActive), .workGroup(workGroup),
      .extBank(extBank), .stackTopPointer(stackTopPointer),
      .flagsValue(flagsValue));
   // ******
   // tasks and scoreboard
   // ******
   task chk(input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // strobes drop a cycle before the next request to avoid double drive
   task wr(input logic [7:0] a, d);
      @(negedge clk) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
      @(negedge clk) regWrEn = 0;
   endtask
   task rd(input logic [7:0] a, e);
      @(negedge clk) {regAddr, regRdEn} = {a, 1'b1};
      if (a >= 8'hfb) q.push_back(e);
      @(negedge clk) regRdEn = 0;
      if (a < 8'hfb) chk({regRdHit, regRdData}, 16'h0000);
   endtask
   function logic cm(input logic [3:0] cc, input logic [7:0] fl);
      logic c, z, s, v;
      {c, z, s, v} = fl[7:4];
      case (cc[2:0])
         0: cm = 0;
         1: cm = s ^ v;
         2: cm = z | (s ^ v);
         3: cm = c | z;
         4: cm = v;
         5: cm = s;
         6: cm = z;
         default: cm = c;
      endcase
      if (cc[3]) cm = !cm;
   endfunction
   always @(negedge clk) if (regRdHit === 1'b1) chk(regRdData, q.pop_front());
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         complete_run;
      end
   end
   initial begin
      void'($urandom(32'hc09b7c04));
      repeat (10) @(negedge clk);
      rst_n = 1;
      for (int a = 251; a < 256; a++) rd(8'(a), 8'h00);
      for (int a = 251; a < 256; a++) begin
         f = $urandom;
         wr(8'(a), f);
         rd(8'(a), f);
      end
      wr(8'hfa, 8'h55);
      rd(8'hfa, 8'h00);
      rd(8'h00, 8'h00);
      sp = $urandom;
      wr(8'hfe, sp[15:8]);
      wr(8'hff, sp[7:0]);
      chk(stackTopPointer, sp);
      sp = $urandom;
      @(negedge clk) {spLoadValue, spLoadEn} = {sp, 1'b1};
      @(negedge clk) spLoadEn = 0;
      rd(8'hfe, sp[15:8]);
      rd(8'hff, sp[7:0]);
      f = $urandom;
      wr(8'hfd, f);
      chk({workGroup, extBank}, f);
      wr(8'hfb, 8'h7f);
      chk({irqGlobalEnable, ramProtectActive, irqEnable}, 8'h7f);
      @(negedge clk) eiStrobe = 1;
      @(negedge clk) eiStrobe = 0;
      rd(8'hfb, 8'hff);
      @(negedge clk) diStrobe = 1;
      @(negedge clk) diStrobe = 0;
      rd(8'hfb, 8'h7f);
      // carry clear, zero set, sign and half from result, rest kept
      repeat (4) begin
         f = $urandom;
         wr(8'hfc, f);
         flagResult = $urandom;
         @(negedge clk) {flagEffect, flagUpdEn} = {18'h0a623, 1'b1};
         @(negedge clk) flagUpdEn = 0;
         chk(flagsValue[1:0], f[1:0]);
         rd(8'hfc, {2'b01, flagResult[3], f[4:3], flagResult[0], f[1:0]});
      end
      repeat (8) begin
         f = $urandom;
         wr(8'hfc, f);
         for (int k = 0; k < 16; k++) begin
            @(negedge clk) condCode = 4'(k);
            #1 chk(condTrue, cm(4'(k), f));
         end
      end
      @(negedge clk);
      complete_run;
   end
endmodule // tb_cfe_flags_cond
bind cfe_flags_cond cfe_flags_cond_assertions cfe_flags_cond_assertions_i (
   .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
   .regWrData(regWrData), .regRdEn(regRdEn), .regRdHit(regRdHit),
   .eiStrobe(eiStrobe), .condCode(condCode), .condTrue(condTrue),
   .irqGlobalEnable(irqGlobalEnable), .workGroup(workGroup),
   .extBank(extBank), .flagsValue(flagsValue));
